// ---- hdl/usb_sec_pkg.sv ----
// shared constants and carrier types for the usb status, error and control registers
package usb_sec_pkg;

    // register byte offsets on the plain register port
    localparam logic [7:0] OFF_ERR_EN = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_CONTROL = 8'h08;
    localparam logic [7:0] OFF_ERR_FLAG = 8'h0c;
    localparam logic [7:0] OFF_IRQ_EN = 8'h10;
    localparam logic [7:0] OFF_IRQ_FLAG = 8'h14;

    // control register fields
    localparam int CTL_J_STATE = 7;
    localparam int CTL_SE0 = 6;
    localparam int CTL_PKT_OFF = 5;
    localparam int CTL_BUS_RESET = 4;
    localparam int CTL_HOST_EN = 3;
    localparam int CTL_RESUME = 2;
    localparam int CTL_PP_RESET = 1;
    localparam int CTL_ENABLE = 0;

    // interrupt enable and flag register fields
    localparam int IRQ_ERROR = 1;
    localparam int IRQ_TRN_DONE = 3;

    // status register field position
    localparam int STAT_LSB = 2;
    localparam int STAT_DEPTH = 4;

    // reset values
    localparam logic [7:0] ERR_EN_RESET = 8'h00;
    localparam logic [5:0] CTL_RESET = 6'h00;
    localparam logic [3:0] IRQ_EN_RESET = 4'h0;

    // frame timing
    localparam int SOF_PERIOD_US = 1000;
    localparam int CLK_MHZ = 25;
    localparam int SOF_CYCLES = SOF_PERIOD_US * CLK_MHZ;

    // one status entry, ordered as it appears in status bits 7..2
    typedef struct packed {
        logic [3:0] endpoint;
        logic dir_tx;
        logic odd_bank;
    } stat_entry_t;

    // error events, ordered as the enable bits 7..0
    typedef struct packed {
        logic bit_stuff;
        logic bus_matrix;
        logic dma;
        logic turnaround_timeout;
        logic field_size;
        logic data_crc;
        logic token_crc_or_frame_end;
        logic pid_check;
    } err_events_t;

    // one register port request
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic we;
        logic re;
    } reg_req_t;

endpackage : usb_sec_pkg

// ---- hdl/status_fifo.sv ----
// four-entry transaction status fifo with a registered head
`timescale 1ns/1ps
module status_fifo
    import usb_sec_pkg::*;
(
    // clock
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    // fill side
    input wire logic push,
    input wire stat_entry_t din,
    output logic full,
    // drain side
    input wire logic pop,
    output stat_entry_t head,
    output logic not_empty
);

    stat_entry_t mem [STAT_DEPTH];
    logic [1:0] wr_ptr_reg;
    logic [1:0] rd_ptr_reg;
    logic [2:0] count_reg;
    logic do_push;
    logic do_pop;
    logic [1:0] rd_ptr_next;
    logic [2:0] count_next;

    assign full = (count_reg == 3'(STAT_DEPTH));
    assign not_empty = (count_reg != 3'h0);
    assign do_push = push && !full;
    assign do_pop = pop && not_empty;
    assign rd_ptr_next = rd_ptr_reg + 2'(do_pop);
    assign count_next = count_reg + 3'(do_push) - 3'(do_pop);

    // storage is left unreset, its content is meaningless until pushed
    always_ff @(posedge clk) begin
        if (ce && do_push) begin
            mem[wr_ptr_reg] <= din;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            wr_ptr_reg <= 2'h0;
            rd_ptr_reg <= 2'h0;
            count_reg <= 3'h0;
        end else if (ce) begin
            wr_ptr_reg <= wr_ptr_reg + 2'(do_push);
            rd_ptr_reg <= rd_ptr_next;
            count_reg <= count_next;
        end
    end

    // bypass the entry being written when it becomes the head at once
    always_ff @(posedge clk) begin
        if (reset) begin
            head <= '0;
        end else if (ce) begin
            if (do_push && rd_ptr_next == wr_ptr_reg) begin
                head <= din;
            end else begin
                head <= mem[rd_ptr_next];
            end
        end
    end

endmodule : status_fifo

// ---- hdl/usb_status_error_control.sv ----
// usb error enables, transaction status fifo window and control register
//
// Overview of operation
// - enable bits 7..4 gate bit stuff, bus matrix, dma, turnaround errors
// - enable bits 3, 2, 0 gate field size, data crc, pid check errors
// - enable bit 1 gates token crc in device, frame end in host
// - enabled errors reach module interrupt only with error interrupt enable set
// - upper 24 bits of enable, status, control read zero
// - status bits 7..4 give endpoint of oldest transfer not yet cleared
// - status bit 3 is one for transmit, zero for receive
// - status bit 2 is one for odd bank, zero for even
// - status shows head of four-entry fifo pushed on completion
// - clearing transaction done flag pops fifo, next entry shows
// - control bit 7 shows live j state
// - control bit 6 shows live single-ended zero
// - device bit 5 disables packets, set by setup, cleared by software
// - host bit 5 reads one while a token executes
// - host bit 4 drives bus reset until written back to zero
// - every toggle of host enable resets host control logic
// - host with frame start enable sends start of frame every 1 ms
//
// The plain strobed port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module usb_status_error_control
    import usb_sec_pkg::*;
#(
    parameter int SOF_PERIOD_CYCLES = SOF_CYCLES
)
(
    // clock, reset, freeze
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    // register port
    input wire reg_req_t req,
    output logic [31:0] rdata,
    // bus line pins
    input wire logic dp_pin,
    input wire logic dm_pin,
    // protocol engine events
    input wire err_events_t err_events,
    input wire logic trn_push,
    input wire stat_entry_t trn_entry,
    input wire logic setup_token,
    input wire logic token_busy,
    // status fifo back-pressure
    output logic trn_full,
    // interrupt
    output logic module_irq_flag,
    // control outputs
    output logic host_mode,
    output logic module_enable,
    output logic frame_start_en,
    output logic pingpong_pointer_reset,
    output logic packet_processing_off,
    output logic bus_reset_drive,
    output logic resume_drive,
    output logic low_speed_eop,
    output logic host_logic_reset,
    output logic sof_request
);

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction : hit

    logic [7:0] err_en_reg;
    logic [7:0] err_flag_reg;
    logic [3:0] irq_en_reg;
    logic [5:0] ctl_reg;
    logic dp_meta_reg;
    logic dp_sync_reg;
    logic dm_meta_reg;
    logic dm_sync_reg;
    logic [14:0] sof_cnt_reg;
    logic err_irq;
    logic trn_flag;
    logic trn_pop;
    logic host_next;
    logic live_j;
    logic live_se0;
    logic wr_ctl;
    stat_entry_t stat_head;
    logic [7:0] ctl_read;

    assign wr_ctl = req.we && hit(req.addr, OFF_CONTROL);
    assign host_next = wr_ctl ? req.wdata[CTL_HOST_EN] : ctl_reg[CTL_HOST_EN];

    // line pins come from outside, two flops before use
    always_ff @(posedge clk) begin
        if (reset) begin
            dp_meta_reg <= 1'b0;
            dp_sync_reg <= 1'b0;
            dm_meta_reg <= 1'b0;
            dm_sync_reg <= 1'b0;
        end else if (ce) begin
            dp_meta_reg <= dp_pin;
            dp_sync_reg <= dp_meta_reg;
            dm_meta_reg <= dm_pin;
            dm_sync_reg <= dm_meta_reg;
        end
    end

    // full-speed idle is j: d+ high, d- low
    assign live_j = dp_sync_reg && !dm_sync_reg;
    assign live_se0 = !dp_sync_reg && !dm_sync_reg;

    // error enable register
    always_ff @(posedge clk) begin
        if (reset) begin
            err_en_reg <= ERR_EN_RESET;
        end else if (ce && req.we && hit(req.addr, OFF_ERR_EN)) begin
            err_en_reg <= req.wdata[7:0];
        end
    end

    // sticky error flags, write one to clear, a new event beats the clear
    always_ff @(posedge clk) begin
        if (reset) begin
            err_flag_reg <= 8'h00;
        end else if (ce) begin
            if (req.we && hit(req.addr, OFF_ERR_FLAG)) begin
                err_flag_reg <= (err_flag_reg & ~req.wdata[7:0]) | err_events;
            end else begin
                err_flag_reg <= err_flag_reg | err_events;
            end
        end
    end

    assign err_irq = |(err_flag_reg & err_en_reg);

    // interrupt enable register
    always_ff @(posedge clk) begin
        if (reset) begin
            irq_en_reg <= IRQ_EN_RESET;
        end else if (ce && req.we && hit(req.addr, OFF_IRQ_EN)) begin
            irq_en_reg <= req.wdata[3:0];
        end
    end

    // done flag tracks the fifo, so a push during the clear is kept unless the fifo is already full
    assign trn_pop = req.we && hit(req.addr, OFF_IRQ_FLAG) && req.wdata[IRQ_TRN_DONE];

    status_fifo u_fifo (
        .clk(clk),
        .reset(reset),
        .ce(ce),
        .push(trn_push),
        .din(trn_entry),
        .full(trn_full),
        .pop(trn_pop),
        .head(stat_head),
        .not_empty(trn_flag)
    );

    always_ff @(posedge clk) begin
        if (reset) begin
            module_irq_flag <= 1'b0;
        end else if (ce) begin
            module_irq_flag <= (err_irq && irq_en_reg[IRQ_ERROR])
                || (trn_flag && irq_en_reg[IRQ_TRN_DONE]);
        end
    end

    // control register; bit 5 is packet disable only in device mode
    always_ff @(posedge clk) begin
        if (reset) begin
            ctl_reg <= CTL_RESET;
        end else if (ce) begin
            if (wr_ctl) begin
                ctl_reg[4:0] <= req.wdata[4:0];
            end
            if (setup_token && !ctl_reg[CTL_HOST_EN]) begin
                ctl_reg[CTL_PKT_OFF] <= 1'b1;
            end else if (wr_ctl && !ctl_reg[CTL_HOST_EN]) begin
                ctl_reg[CTL_PKT_OFF] <= req.wdata[CTL_PKT_OFF];
            end
        end
    end

    // registered outputs; bus reset and packet disable follow the register one cycle later
    always_ff @(posedge clk) begin
        if (reset) begin
            host_logic_reset <= 1'b0;
            low_speed_eop <= 1'b0;
            bus_reset_drive <= 1'b0;
            packet_processing_off <= 1'b0;
        end else if (ce) begin
            host_logic_reset <= (host_next != ctl_reg[CTL_HOST_EN]);
            low_speed_eop <= ctl_reg[CTL_HOST_EN] && ctl_reg[CTL_RESUME]
                && wr_ctl && !req.wdata[CTL_RESUME];
            bus_reset_drive <= ctl_reg[CTL_HOST_EN] && ctl_reg[CTL_BUS_RESET];
            packet_processing_off <= !ctl_reg[CTL_HOST_EN] && ctl_reg[CTL_PKT_OFF];
        end
    end

    assign host_mode = ctl_reg[CTL_HOST_EN];
    assign resume_drive = ctl_reg[CTL_RESUME];
    assign pingpong_pointer_reset = ctl_reg[CTL_PP_RESET];
    assign module_enable = !ctl_reg[CTL_HOST_EN] && ctl_reg[CTL_ENABLE];
    assign frame_start_en = ctl_reg[CTL_HOST_EN] && ctl_reg[CTL_ENABLE];

    // frame timer; a host enable toggle restarts it with the rest of host logic
    always_ff @(posedge clk) begin
        if (reset) begin
            sof_cnt_reg <= 15'h0000;
            sof_request <= 1'b0;
        end else if (ce) begin
            sof_request <= 1'b0;
            if (!frame_start_en || host_logic_reset) begin
                sof_cnt_reg <= 15'h0000;
            end else if (sof_cnt_reg == 15'(SOF_PERIOD_CYCLES - 1)) begin
                sof_cnt_reg <= 15'h0000;
                sof_request <= 1'b1;
            end else begin
                sof_cnt_reg <= sof_cnt_reg + 15'h0001;
            end
        end
    end

    always_comb begin
        ctl_read = {live_j, live_se0, ctl_reg[5:0]};
        if (ctl_reg[CTL_HOST_EN]) begin
            ctl_read[CTL_PKT_OFF] = token_busy;
        end
    end

    // read data stand only in the cycle after the strobe
    always_ff @(posedge clk) begin
        if (reset) begin
            rdata <= 32'h0000_0000;
        end else if (ce) begin
            rdata <= 32'h0000_0000;
            if (req.re) begin
                case (req.addr)
                    OFF_ERR_EN: rdata[7:0] <= err_en_reg;
                    OFF_STATUS: rdata[7:STAT_LSB] <= stat_head;
                    OFF_CONTROL: rdata[7:0] <= ctl_read;
                    OFF_ERR_FLAG: rdata[7:0] <= err_flag_reg;
                    OFF_IRQ_EN: rdata[3:0] <= irq_en_reg;
                    OFF_IRQ_FLAG: rdata[3:0] <= {trn_flag, 1'b0, err_irq, 1'b0};
                    default: rdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // the stuck-off case a lost enable would cause
    irq_on_error_a: assert property (@(posedge clk) disable iff (reset)
        (ce && irq_en_reg[IRQ_ERROR] && |(err_flag_reg & err_en_reg)) |=> module_irq_flag)
        else $error("enabled error did not raise module interrupt");

    irq_quiet_a: assert property (@(posedge clk) disable iff (reset)
        (ce && !(irq_en_reg[IRQ_ERROR] && err_irq) && !(irq_en_reg[IRQ_TRN_DONE] && trn_flag))
        |=> !module_irq_flag)
        else $error("module interrupt without an enabled cause");

    stuff_err_path_a: assert property (@(posedge clk) disable iff (reset)
        (ce && err_events.bit_stuff && err_en_reg[7] && irq_en_reg[IRQ_ERROR]
        && !(req.we && (hit(req.addr, OFF_IRQ_EN) || hit(req.addr, OFF_ERR_EN))))
        ##1 ce |=> module_irq_flag)
        else $error("bit stuff error did not reach interrupt");

    crc_mask_a: assert property (@(posedge clk) disable iff (reset)
        (ce && err_flag_reg == 8'h04 && !err_en_reg[2]) |-> !err_irq)
        else $error("masked data crc error requested interrupt");

    token_crc_a: assert property (@(posedge clk) disable iff (reset)
        (ce && err_flag_reg[1] && err_en_reg[1]) |-> err_irq)
        else $error("enabled bit 1 error not combined");

    upper_zero_a: assert property (@(posedge clk) disable iff (reset)
        (ce && req.re) |=> rdata[31:8] == 24'h000000)
        else $error("upper read bits not zero");

    status_read_a: assert property (@(posedge clk) disable iff (reset)
        (ce && req.re && hit(req.addr, OFF_STATUS)) |=> rdata[7:0] == {$past(stat_head), 2'b00})
        else $error("status read does not show fifo head");

    pop_empty_a: assert property (@(posedge clk) disable iff (reset)
        (ce && trn_pop && !trn_push && u_fifo.count_reg == 3'h1) |=> !trn_flag)
        else $error("clearing last done flag did not empty fifo");

    setup_disable_a: assert property (@(posedge clk) disable iff (reset)
        (ce && setup_token && !ctl_reg[CTL_HOST_EN]) |=> ctl_reg[CTL_PKT_OFF])
        else $error("setup token did not disable packets");

    token_busy_a: assert property (@(posedge clk) disable iff (reset)
        (ce && req.re && hit(req.addr, OFF_CONTROL) && ctl_reg[CTL_HOST_EN])
        |=> rdata[CTL_PKT_OFF] == $past(token_busy))
        else $error("host bit 5 does not follow token busy");

    bus_reset_a: assert property (@(posedge clk) disable iff (reset)
        (ce && ctl_reg[CTL_HOST_EN] && ctl_reg[CTL_BUS_RESET]) |=> bus_reset_drive)
        else $error("host bus reset not driven");

    host_toggle_a: assert property (@(posedge clk) disable iff (reset)
        (ce && wr_ctl && req.wdata[CTL_HOST_EN] != ctl_reg[CTL_HOST_EN]) |=> host_logic_reset)
        else $error("host enable toggle gave no host reset");

    sof_spacing_a: assert property (@(posedge clk) disable iff (reset)
        (sof_request && ce) |=> !sof_request)
        else $error("start of frame requests back to back");

    sof_gate_a: assert property (@(posedge clk) disable iff (reset)
        sof_request |-> $past(frame_start_en))
        else $error("start of frame without frame start enable");

    j_read_a: assert property (@(posedge clk) disable iff (reset)
        (ce && req.re && hit(req.addr, OFF_CONTROL))
        |=> rdata[CTL_J_STATE] == ($past(dp_sync_reg) && !$past(dm_sync_reg)))
        else $error("control bit 7 does not show the j state");

    se0_read_a: assert property (@(posedge clk) disable iff (reset)
        (ce && req.re && hit(req.addr, OFF_CONTROL))
        |=> rdata[CTL_SE0] == (!$past(dp_sync_reg) && !$past(dm_sync_reg)))
        else $error("control bit 6 does not show single-ended zero");

    idle_rdata_a: assert property (@(posedge clk) disable iff (reset)
        (ce && !req.re) |=> rdata == 32'h0000_0000)
        else $error("read data stand past their cycle");

    err_en_write_a: assert property (@(posedge clk) disable iff (reset)
        (ce && req.we && hit(req.addr, OFF_ERR_EN))
        |=> err_en_reg == $past(req.wdata[7:0]))
        else $error("error enable write did not land");

    host_pkt_hold_a: assert property (@(posedge clk) disable iff (reset)
        (ce && ctl_reg[CTL_HOST_EN]) |=> $stable(ctl_reg[CTL_PKT_OFF]))
        else $error("packet disable changed in host mode");

    first_entry_a: assert property (@(posedge clk) disable iff (reset)
        (ce && trn_push && !trn_flag) |=> stat_head == $past(trn_entry))
        else $error("first status entry not at the head");

    fifo_full_a: assert property (@(posedge clk) disable iff (reset)
        (ce && trn_push && !trn_pop && u_fifo.count_reg == 3'h3) |=> trn_full)
        else $error("fourth status entry did not fill the fifo");

    bus_reset_off_a: assert property (@(posedge clk) disable iff (reset)
        (ce && !ctl_reg[CTL_BUS_RESET]) |=> !bus_reset_drive)
        else $error("bus reset driven while not requested");

endmodule : usb_status_error_control

// ---- tb/usb_line_partner.sv ----
// model of the cable partner: drives the bus line levels seen by the block
`timescale 1ns/1ps
module usb_line_partner (
    // clock
    input wire logic clk,
    // scenario command: 0 j, 1 k, 2 se0, 3 changing pattern
    input wire logic [1:0] line_cmd,
    // our own bus reset overrides the line
    input wire logic bus_reset_drive,
    // line levels
    output logic dp,
    output logic dm
);
    logic toggle_reg;
    initial toggle_reg = 1'b0;
    always @(posedge clk) toggle_reg <= ~toggle_reg;
    // a driven reset wins over the partner's idle, the line then shows se0
    always_comb begin
        if (bus_reset_drive) begin
            {dp, dm} = 2'b00;
        end else begin
            case (line_cmd)
                2'd0: {dp, dm} = 2'b10;
                2'd1: {dp, dm} = 2'b01;
                2'd2: {dp, dm} = 2'b00;
                default: {dp, dm} = {toggle_reg, ~toggle_reg};
            endcase
        end
    end
endmodule : usb_line_partner

// ---- tb/test_usb_status_error_control.sv ----
// self-checking bench for the usb status, error enable and control registers
`timescale 1ns/1ps
module test_usb_status_error_control;
    import usb_sec_pkg::*;
    localparam int SOF_SIM = 20;
    logic clk = 1'b0, reset = 1'b1, ce = 1'b1;
    reg_req_t req = '0;
    logic [31:0] rdata, q, seed = 32'haff1;
    logic dp_pin, dm_pin, trn_push = 1'b0, setup_token = 1'b0, token_busy = 1'b0;
    err_events_t err_events = '0;
    stat_entry_t trn_entry = '0;
    stat_entry_t ent [5];
    logic trn_full, module_irq_flag, host_mode, module_enable, frame_start_en;
    logic pingpong_pointer_reset, packet_processing_off, bus_reset_drive, resume_drive;
    logic low_speed_eop, host_logic_reset, sof_request;
    logic [1:0] line_cmd = 2'd0;
    logic [7:0] en;
    int failures = 0, comparisons = 0, hlr_cnt = 0, sof_cnt = 0, eop_cnt = 0;

    always #20 clk = ~clk;
    always @(posedge clk) begin
        hlr_cnt <= hlr_cnt + int'(host_logic_reset === 1'b1);
        sof_cnt <= sof_cnt + int'(sof_request === 1'b1);
        eop_cnt <= eop_cnt + int'(low_speed_eop === 1'b1);
    end

    usb_status_error_control #(.SOF_PERIOD_CYCLES(SOF_SIM)) u_dut (
        .clk(clk), .reset(reset), .ce(ce), .req(req), .rdata(rdata),
        .dp_pin(dp_pin), .dm_pin(dm_pin), .err_events(err_events),
        .trn_push(trn_push), .trn_entry(trn_entry), .setup_token(setup_token),
        .token_busy(token_busy), .trn_full(trn_full), .module_irq_flag(module_irq_flag),
        .host_mode(host_mode), .module_enable(module_enable),
        .frame_start_en(frame_start_en), .pingpong_pointer_reset(pingpong_pointer_reset),
        .packet_processing_off(packet_processing_off), .bus_reset_drive(bus_reset_drive),
        .resume_drive(resume_drive), .low_speed_eop(low_speed_eop),
        .host_logic_reset(host_logic_reset), .sof_request(sof_request)
    );
    usb_line_partner u_partner (
        .clk(clk), .line_cmd(line_cmd), .bus_reset_drive(bus_reset_drive),
        .dp(dp_pin), .dm(dm_pin)
    );

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
            failures++;
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        req <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
        @(posedge clk);
        req <= '{addr: a, wdata: d, we: 1'b0, re: 1'b0};
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        req <= '{addr: a, wdata: 32'h0, we: 1'b0, re: 1'b1};
        @(posedge clk);
        req <= '{addr: a, wdata: 32'h0, we: 1'b0, re: 1'b0};
        #1 d = rdata;
    endtask : rd

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        rd(a, q);
        chk(q, exp);
    endtask : rdchk

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : wait_clk

    task automatic print_verdict;
        $display("comparisons=%0d failures=%0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : print_verdict

    // a hang anywhere ends the run as a mismatch
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        print_verdict();
    end

    initial begin
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        rdchk(OFF_ERR_EN, 32'h0);
        rdchk(OFF_IRQ_EN, 32'h0);
        rdchk(OFF_CONTROL, 32'h80);
        rdchk(8'h20, 32'h0);
        // a write while the clock enable is low must not land
        @(posedge clk) ce <= 1'b0;
        wr(OFF_ERR_EN, 32'hff);
        ce <= 1'b1;
        rdchk(OFF_ERR_EN, 32'h0);
        // error gating, once with the error interrupt off and once on
        for (int pass = 0; pass < 2; pass++) begin
            wr(OFF_IRQ_EN, 32'(pass) << IRQ_ERROR);
            for (int i = 0; i < 8; i++) begin
                seed = lfsr_next(seed);
                en = (i == 7) ? 8'hff : (i == 0) ? 8'hfe : seed[7:0];
                wr(OFF_ERR_EN, {seed[31:8], en});
                rdchk(OFF_ERR_EN, {24'h0, en});
                @(posedge clk);
                err_events <= err_events_t'(8'h1 << i);
                @(posedge clk);
                err_events <= '0;
                wait_clk(2);
                chk({31'h0, module_irq_flag}, {31'h0, en[i] & pass[0]});
                rdchk(OFF_ERR_FLAG, 32'h1 << i);
                rdchk(OFF_IRQ_FLAG, {30'h0, en[i], 1'b0});
                wr(OFF_ERR_FLAG, 32'hff);
                wait_clk(2);
                chk({31'h0, module_irq_flag}, 32'h0);
            end
        end
        wr(OFF_ERR_EN, 32'h0);
        // five back-to-back pushes into four places, the last one dropped
        for (int k = 0; k < 5; k++) begin
            seed = lfsr_next(seed);
            ent[k] = stat_entry_t'(seed[5:0]);
        end
        ent[0].endpoint = 4'hf;
        ent[3].endpoint = 4'h0;
        for (int k = 0; k < 5; k++) begin
            @(posedge clk);
            trn_push <= 1'b1;
            trn_entry <= ent[k];
        end
        @(posedge clk);
        trn_push <= 1'b0;
        #1 chk({31'h0, trn_full}, 32'h1);
        for (int k = 0; k < 4; k++) begin
            rd(OFF_IRQ_FLAG, q);
            chk({31'h0, q[IRQ_TRN_DONE]}, 32'h1);
            rdchk(OFF_STATUS, {24'h0, ent[k], 2'b00});
            wr(OFF_IRQ_FLAG, 32'h1 << IRQ_TRN_DONE);
        end
        rd(OFF_IRQ_FLAG, q);
        chk({31'h0, q[IRQ_TRN_DONE]}, 32'h0);
        // live line state follows the partner
        line_cmd <= 2'd2;
        wait_clk(4);
        rdchk(OFF_CONTROL, 32'h40);
        line_cmd <= 2'd1;
        wait_clk(4);
        rdchk(OFF_CONTROL, 32'h0);
        line_cmd <= 2'd0;
        // device mode: setup freezes packet processing until software clears it
        wr(OFF_CONTROL, 32'h3);
        @(posedge clk);
        setup_token <= 1'b1;
        @(posedge clk);
        setup_token <= 1'b0;
        wait_clk(3);
        chk({31'h0, packet_processing_off}, 32'h1);
        rdchk(OFF_CONTROL, 32'ha3);
        chk({31'h0, pingpong_pointer_reset}, 32'h1);
        chk({31'h0, module_enable}, 32'h1);
        wr(OFF_CONTROL, 32'h1);
        wait_clk(2);
        chk({31'h0, packet_processing_off}, 32'h0);
        // host mode
        wr(OFF_CONTROL, 32'h08);
        wait_clk(3);
        chk(32'(hlr_cnt), 32'h1);
        chk({31'h0, host_mode}, 32'h1);
        @(posedge clk) token_busy <= 1'b1;
        rdchk(OFF_CONTROL, 32'ha8);
        @(posedge clk) token_busy <= 1'b0;
        rdchk(OFF_CONTROL, 32'h88);
        wr(OFF_CONTROL, 32'h18);
        wait_clk(2);
        chk({31'h0, bus_reset_drive}, 32'h1);
        wait_clk(4);
        rdchk(OFF_CONTROL, 32'h58);
        wr(OFF_CONTROL, 32'h08);
        wait_clk(2);
        chk({31'h0, bus_reset_drive}, 32'h0);
        wr(OFF_CONTROL, 32'h09);
        wait_clk(SOF_SIM + 5);
        chk({31'h0, frame_start_en}, 32'h1);
        q = 32'(sof_cnt);
        wait_clk(5 * SOF_SIM);
        chk(32'(sof_cnt) - q, 32'h5);
        // resume held briefly; a real wake-up hold would dominate the run
        wr(OFF_CONTROL, 32'h0c);
        wait_clk(10);
        chk({31'h0, resume_drive}, 32'h1);
        wr(OFF_CONTROL, 32'h08);
        wait_clk(3);
        chk(32'(eop_cnt), 32'h1);
        wr(OFF_CONTROL, 32'h0);
        wait_clk(3);
        chk(32'(hlr_cnt), 32'h2);
        // a reset in mid-run clears the enables again
        wr(OFF_ERR_EN, 32'h5a);
        @(posedge clk) reset <= 1'b1;
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        rdchk(OFF_ERR_EN, 32'h0);
        print_verdict();
    end
endmodule : test_usb_status_error_control
